// ===== pkg/wdt_ctl_if.sv
// Purpose: carrier between the watchdog core and its two helpers
// Assumes: one clock domain
// Notes: presc/pcore face the prescaler, irqs/icore the interrupt block
interface wdt_ctl_if;
  logic run;
  logic restart;
  logic [2:0] sel;
  logic tick;
  logic [1:0] ev;
  logic clr_wr;
  logic [1:0] clr_data;
  logic ien_wr;
  logic [1:0] ien_data;
  logic [1:0] status;
  logic [1:0] ien;
  logic irq;
  modport presc (input run, input restart, input sel, output tick);
  modport pcore (output run, output restart, output sel, input tick);
  modport irqs (input ev, input clr_wr, input clr_data, input ien_wr,
    input ien_data, output status, output ien, output irq);
  modport icore (output ev, output clr_wr, output clr_data, output ien_wr,
    output ien_data, input status, input ien, input irq);
endinterface : wdt_ctl_if

// ===== pkg/wdt_pkg.sv
// Purpose: shared constants and types of the watchdog timer unit
// Assumes: byte addressed register bus, 32-bit data
// Notes: all offsets are byte addresses
package wdt_pkg;

  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned ADDR_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [19:0] CTL_ADDR = 20'h40108;
  localparam logic [19:0] STAT_ADDR = 20'h4010c;
  localparam logic [19:0] CLR_ADDR = 20'h40110;
  localparam logic [19:0] IEN_ADDR = 20'h40114;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int unsigned PSC_LSB = 0;
  localparam int unsigned PSC_W = 3;
  localparam int unsigned EN_BIT = 4;
  localparam int unsigned CLR_BIT = 5;
  localparam int unsigned ACT_BIT = 6;
  localparam int unsigned MASK_LSB = 8;
  localparam int unsigned MASK_W = 7;
  localparam int unsigned CNT_LSB = 16;
  localparam int unsigned CNT_W = 15;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0] PSC_RST = 3'h7;
  localparam logic [14:0] CNT_RST = 15'h0000;
  localparam logic [14:0] DIV_RST = 15'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events
  localparam int unsigned EV_W = 2;
  localparam int unsigned EV_OVF = 0;
  localparam int unsigned EV_WDRST = 1;
  localparam logic [1:0] EV_RST = 2'h0;

  typedef enum logic [1:0] {
    WDT_NORMAL = 2'b00,
    WDT_IDLE = 2'b01,
    WDT_SLEEP = 2'b11
  } wdt_pwr_e;

  // last divider count for select code: divide by 2^(2*sel+1)
  function automatic logic [14:0] wdt_div_last(input logic [2:0] sel);
    wdt_div_last = 15'((32'h1 << {sel, 1'b1}) - 32'h1);
  endfunction : wdt_div_last

endpackage : wdt_pkg

// ===== rtl/wdt_irq_regs.sv
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: clear register is write one to clear
// Notes: a set in the clearing cycle wins
module wdt_irq_regs (
  input wire logic clock,
  input wire logic srst,
  wdt_ctl_if.irqs ctl
);

  logic [1:0] next_status;
  logic [1:0] next_ien;

  always_comb
  begin
    next_status = ctl.status;
    if (ctl.clr_wr)
      next_status = next_status & ~ctl.clr_data;
    next_status = next_status | ctl.ev;
    next_ien = ctl.ien_wr ? ctl.ien_data : ctl.ien;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctl.status <= wdt_pkg::EV_RST;
      ctl.ien <= wdt_pkg::EV_RST;
      ctl.irq <= 1'b0;
    end
    else
    begin
      ctl.status <= next_status;
      ctl.ien <= next_ien;
      ctl.irq <= |(next_status & next_ien);
    end
  end

  set_wins_a: assert property (@(posedge clock) disable iff (srst)
    ctl.ev[wdt_pkg::EV_OVF] |=> ctl.status[wdt_pkg::EV_OVF])
    else $error("overflow event lost");

endmodule : wdt_irq_regs

// ===== rtl/wdt_prescaler.sv
// Purpose: counting enable from the low-speed rc clock, divided by select
// Assumes: rc clock far slower than the system clock
// Notes: rc clock is a pin, synchronised before use
module wdt_prescaler (
  input wire logic clock,
  input wire logic srst,
  input wire logic low_speed_rc_clock,
  wdt_ctl_if.presc ctl
);

  logic low_speed_rc_clock_meta;
  logic low_speed_rc_clock_sync;
  logic low_speed_rc_clock_prev;
  logic rise;
  logic [14:0] div;
  logic [14:0] last;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      low_speed_rc_clock_meta <= 1'b0;
      low_speed_rc_clock_sync <= 1'b0;
      low_speed_rc_clock_prev <= 1'b0;
    end
    else
    begin
      low_speed_rc_clock_meta <= low_speed_rc_clock;
      low_speed_rc_clock_sync <= low_speed_rc_clock_meta;
      low_speed_rc_clock_prev <= low_speed_rc_clock_sync;
    end
  end

  assign rise = low_speed_rc_clock_sync & ~low_speed_rc_clock_prev;
  assign last = wdt_pkg::wdt_div_last(ctl.sel);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      div <= wdt_pkg::DIV_RST;
      ctl.tick <= 1'b0;
    end
    else
    begin
      ctl.tick <= 1'b0;
      if (ctl.restart || !ctl.run)
        div <= wdt_pkg::DIV_RST;
      else if (rise)
      begin
        if (div >= last)
        begin
          div <= wdt_pkg::DIV_RST;
          ctl.tick <= 1'b1;
        end
        else
          div <= div + 15'h0001;
      end
    end
  end

  tick_on_edge_a: assert property (@(posedge clock) disable iff (srst)
    ctl.tick |-> $past(rise) && $past(ctl.run))
    else $error("tick without rc clock edge");

endmodule : wdt_prescaler

// ===== rtl/wdt_timer_unit.sv
// Purpose: watchdog timer with avalon-mm control and status register
// Assumes: power mode comes from logic on the same clock
// Notes: chip reset request is a pulse; srst is the full power-on reset
//
// Our own choice: the Avalon-MM slave port.
module wdt_timer_unit #(
  parameter int unsigned COUNT_W = wdt_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [19:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic low_speed_rc_clock,
  input wire wdt_pkg::wdt_pwr_e power_mode,
  output logic chip_reset_req,
  output logic wake_event,
  output logic irq
);

  wdt_ctl_if ctl ();

  logic [2:0] prescale_sel;
  logic run_enable;
  logic action_select;
  logic [COUNT_W-1:0] counter;
  logic acc_wr;
  logic acc_rd;
  logic ctl_wr;
  logic [6:0] upd;
  logic clr_fire;
  logic is_normal;
  logic is_idle;
  logic count_run;
  logic ovf;
  logic [31:0] next_readdata;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  wdt_prescaler u_prescaler (
    .clock(clock),
    .srst(srst),
    .low_speed_rc_clock(low_speed_rc_clock),
    .ctl(ctl.presc)
  );

  wdt_irq_regs u_irq (
    .clock(clock),
    .srst(srst),
    .ctl(ctl.irqs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus access decode

  assign acc_wr = avs_write & ~avs_waitrequest;
  assign acc_rd = avs_read & ~avs_waitrequest;
  assign ctl_wr = acc_wr & (avs_address == wdt_pkg::CTL_ADDR)
    & avs_byteenable[0] & avs_byteenable[1];

  // write mask per control bit
  assign upd = avs_writedata[wdt_pkg::MASK_LSB +: wdt_pkg::MASK_W]
    & {wdt_pkg::MASK_W{ctl_wr}};

  assign clr_fire = upd[wdt_pkg::CLR_BIT]
    & avs_writedata[wdt_pkg::CLR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // power mode and overflow

  assign is_normal = (power_mode == wdt_pkg::WDT_NORMAL);
  assign is_idle = (power_mode == wdt_pkg::WDT_IDLE);
  assign count_run = run_enable & (is_normal | is_idle);
  assign ovf = ctl.tick & count_run & (&counter) & ~clr_fire;

  assign ctl.run = count_run;
  assign ctl.restart = clr_fire;
  assign ctl.sel = prescale_sel;

  // idle always raises the overflow event; normal raises it only in timer mode
  assign ctl.ev[wdt_pkg::EV_OVF] = ovf & (is_idle | ~action_select);
  assign ctl.ev[wdt_pkg::EV_WDRST] = ovf & is_normal & action_select;

  assign ctl.clr_wr = acc_wr & (avs_address == wdt_pkg::CLR_ADDR)
    & avs_byteenable[0];
  assign ctl.clr_data = avs_writedata[1:0];
  assign ctl.ien_wr = acc_wr & (avs_address == wdt_pkg::IEN_ADDR)
    & avs_byteenable[0];
  assign ctl.ien_data = avs_writedata[1:0];

  assign irq = ctl.irq;

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  genvar gi;
  generate
    for (gi = 0; gi < wdt_pkg::PSC_W; gi++)
    begin : g_psc
      always_ff @(posedge clock)
      begin
        if (srst)
          prescale_sel[gi] <= wdt_pkg::PSC_RST[gi];
        else if (upd[wdt_pkg::PSC_LSB + gi])
          prescale_sel[gi] <= avs_writedata[wdt_pkg::PSC_LSB + gi];
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (srst)
      run_enable <= 1'b0;
    else if (upd[wdt_pkg::EN_BIT] && avs_writedata[wdt_pkg::EN_BIT]
      && is_normal)
      run_enable <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      action_select <= 1'b0;
    else if (upd[wdt_pkg::ACT_BIT] && avs_writedata[wdt_pkg::ACT_BIT])
      action_select <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  always_ff @(posedge clock)
  begin
    if (srst)
      counter <= COUNT_W'(wdt_pkg::CNT_RST);
    else if (clr_fire)
      counter <= COUNT_W'(wdt_pkg::CNT_RST);
    else if (ctl.tick && count_run)
      counter <= counter + COUNT_W'(15'h0001);
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow outputs; srst is not driven by our own reset request

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      chip_reset_req <= 1'b0;
      wake_event <= 1'b0;
    end
    else
    begin
      chip_reset_req <= ovf & is_normal & action_select;
      wake_event <= ovf & is_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address)
      wdt_pkg::CTL_ADDR:
      begin
        next_readdata[wdt_pkg::CNT_LSB +: wdt_pkg::CNT_W] =
          15'(counter);
        next_readdata[wdt_pkg::ACT_BIT] = action_select;
        next_readdata[wdt_pkg::CLR_BIT] = 1'b0;
        next_readdata[wdt_pkg::EN_BIT] = run_enable;
        next_readdata[wdt_pkg::PSC_LSB +: wdt_pkg::PSC_W] = prescale_sel;
      end
      wdt_pkg::STAT_ADDR:
        next_readdata[1:0] = ctl.status;
      wdt_pkg::IEN_ADDR:
        next_readdata[1:0] = ctl.ien;
      default:
        next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  reset_on_ovf_a: assert property (
    ovf && is_normal && action_select |=> chip_reset_req && !wake_event)
    else $error("no chip reset on overflow");

  reset_pulse_a: assert property (
    chip_reset_req |-> $past(ovf) && $past(action_select))
    else $error("chip reset without overflow");

  clear_zero_a: assert property (
    clr_fire |=> counter == COUNT_W'(15'h0000))
    else $error("counter not cleared");

  sleep_quiet_a: assert property (
    power_mode == wdt_pkg::WDT_SLEEP && !clr_fire
    |=> $stable(counter) && !chip_reset_req && !wake_event)
    else $error("watchdog active in sleep");

  idle_wake_a: assert property (
    ovf && is_idle |=> wake_event && !chip_reset_req
    && ctl.status[wdt_pkg::EV_OVF])
    else $error("idle overflow did not wake");

  timer_mode_a: assert property (
    ovf && is_normal && !action_select
    |=> !chip_reset_req && ctl.status[wdt_pkg::EV_OVF])
    else $error("timer mode overflow not interrupt");

  action_lock_a: assert property (
    action_select |=> action_select)
    else $error("reset action unlocked");

  enable_lock_a: assert property (
    run_enable |=> run_enable)
    else $error("watchdog disabled after enable");

  start_normal_a: assert property (
    $rose(run_enable) |-> $past(is_normal) && $past(ctl_wr))
    else $error("watchdog started outside normal mode");

  count_read_a: assert property (
    acc_rd && avs_address == wdt_pkg::CTL_ADDR
    |-> avs_readdata[30:16] == 15'($past(counter))
    && avs_readdata[wdt_pkg::CLR_BIT] == 1'b0)
    else $error("counter readback wrong");

  count_step_a: assert property (
    !ctl.tick && !clr_fire |=> $stable(counter))
    else $error("counter moved without tick");

  mask_guard_a: assert property (
    ctl_wr && !avs_writedata[wdt_pkg::MASK_LSB + wdt_pkg::ACT_BIT]
    && !action_select |=> !action_select)
    else $error("masked write changed action");

  wait_answer_a: assert property (
    avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");

  wake_pulse_a: assert property (
    wake_event |-> $past(ovf) && $past(is_idle))
    else $error("wake without idle overflow");

  wake_once_a: assert property (
    wake_event |=> !wake_event)
    else $error("wake pulse too long");

  reset_once_a: assert property (
    chip_reset_req |=> !chip_reset_req)
    else $error("chip reset pulse too long");

  reset_event_a: assert property (
    ovf && is_normal && action_select
    |=> ctl.status[wdt_pkg::EV_WDRST])
    else $error("reset event not recorded");

  clear_restart_a: assert property (
    clr_fire |=> !ctl.tick)
    else $error("prescaler not restarted by clear");

  sleep_no_tick_a: assert property (
    power_mode == wdt_pkg::WDT_SLEEP |=> !ctl.tick)
    else $error("prescaler ticks in sleep");

  idle_no_reset_a: assert property (
    is_idle |=> !chip_reset_req)
    else $error("chip reset from idle");

  normal_no_wake_a: assert property (
    is_normal |=> !wake_event)
    else $error("wake event in normal mode");

  enable_mode_a: assert property (
    !run_enable && !is_normal |=> !run_enable)
    else $error("enabled outside normal mode");

  psc_mask_a: assert property (
    ctl_wr && !avs_writedata[wdt_pkg::MASK_LSB + wdt_pkg::PSC_LSB]
    |=> $stable(prescale_sel[0]))
    else $error("masked prescale bit changed");

  psc_write_a: assert property (
    upd[wdt_pkg::PSC_LSB]
    |=> prescale_sel[0] == $past(avs_writedata[wdt_pkg::PSC_LSB]))
    else $error("prescale write lost");

  count_inc_a: assert property (
    ctl.tick && count_run && !clr_fire
    |=> counter == COUNT_W'($past(counter) + COUNT_W'(15'h0001)))
    else $error("counter missed a tick");

  status_read_a: assert property (
    acc_rd && avs_address == wdt_pkg::STAT_ADDR
    |-> avs_readdata == {30'h0000_0000, $past(ctl.status)})
    else $error("status readback wrong");

  irq_level_a: assert property (
    irq == |(ctl.status & ctl.ien))
    else $error("interrupt level wrong");

  wait_one_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");

  enable_read_a: assert property (
    acc_rd && avs_address == wdt_pkg::CTL_ADDR
    |-> avs_readdata[wdt_pkg::EN_BIT] == $past(run_enable))
    else $error("enable readback wrong");

endmodule : wdt_timer_unit

// ===== tb/wdt_timer_unit_tb.sv
// Purpose: self-checking bench of the watchdog timer unit
// Assumes: one clock, single-word avalon-mm accesses, rc period 6 clocks
// Notes: counter narrowed to 4 bits so overflow fits the run budget
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) \
    begin \
      n_errors++; \
      $display("[ERR] %s exp %h got %h", nm, ex, gt); \
    end \
  end

module wdt_timer_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [19:0] avs_address = 20'h00000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic low_speed_rc_clock = 1'b0;
  wdt_pkg::wdt_pwr_e power_mode = wdt_pkg::WDT_NORMAL;
  logic chip_reset_req;
  logic wake_event;
  logic irq;
  logic pulse_seen = 1'b0;
  logic [31:0] rd;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int rst_pulses = 0;
  int wake_pulses = 0;

  always #50 clock = ~clock;

  wdt_timer_unit #(.COUNT_W(4)) uut (
    .clock(clock),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .low_speed_rc_clock(low_speed_rc_clock),
    .power_mode(power_mode),
    .chip_reset_req(chip_reset_req),
    .wake_event(wake_event),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // monitors and timeout
  always @(posedge clock)
  begin
    if (chip_reset_req === 1'b1 || wake_event === 1'b1)
      pulse_seen <= 1'b1;
    if (chip_reset_req === 1'b1)
      rst_pulses <= rst_pulses + 1;
    if (wake_event === 1'b1)
      wake_pulses <= wake_pulses + 1;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  task conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // bus and rc stimulus
  task automatic bus_wr(input logic [19:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus_wr

  task automatic bus_rd(input logic [19:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus_rd

  task automatic rc_edges(input int n);
    repeat (n)
    begin
      low_speed_rc_clock <= 1'b1;
      repeat (3) @(posedge clock);
      low_speed_rc_clock <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask : rc_edges

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task test_reset;
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("ctl reset", 32'h00000007, rd)
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("status reset", 32'h0, rd)
    bus_rd(wdt_pkg::IEN_ADDR, rd);
    `CHK("ien reset", 32'h0, rd)
    bus_rd(20'h40200, rd);
    `CHK("unmapped read", 32'h0, rd)
    $display("test reset done");
  endtask : test_reset

  task test_mask;
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00000010);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("unmasked write", 32'h00000007, rd)
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00000700);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("masked prescale", 32'h00000000, rd)
    $display("test mask done");
  endtask : test_mask

  task test_enable;
    power_mode <= wdt_pkg::WDT_IDLE;
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00001010);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("enable in idle", 1'b0, rd[4])
    power_mode <= wdt_pkg::WDT_NORMAL;
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00001010);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("enable in normal", 1'b1, rd[4])
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00001000);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("enable locked", 1'b1, rd[4])
    $display("test enable done");
  endtask : test_enable

  task test_count;
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00002020);
    rc_edges(8);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("count div2", 15'h0004, rd[30:16])
    `CHK("clear reads 0", 1'b0, rd[5])
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00000101);
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00002020);
    rc_edges(16);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("count div8", 15'h0002, rd[30:16])
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00002020);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("count cleared", 15'h0000, rd[30:16])
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00000100);
    $display("test count done");
  endtask : test_count

  task test_modes;
    power_mode <= wdt_pkg::WDT_SLEEP;
    rc_edges(8);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("sleep frozen", 15'h0000, rd[30:16])
    power_mode <= wdt_pkg::WDT_IDLE;
    rc_edges(8);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("idle counts", 15'h0004, rd[30:16])
    power_mode <= wdt_pkg::WDT_NORMAL;
    `CHK("no pulse", 1'b0, pulse_seen)
    $display("test modes done");
  endtask : test_modes

  task test_action;
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00004040);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("action set", 1'b1, rd[6])
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00004000);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("action locked", 1'b1, rd[6])
    $display("test action done");
  endtask : test_action

  task test_irq_regs;
    bus_wr(wdt_pkg::IEN_ADDR, 32'h00000003);
    bus_rd(wdt_pkg::IEN_ADDR, rd);
    `CHK("ien rw", 32'h00000003, rd)
    `CHK("irq idle", 1'b0, irq)
    bus_wr(wdt_pkg::CLR_ADDR, 32'h00000003);
    bus_rd(wdt_pkg::CLR_ADDR, rd);
    `CHK("clear reads 0", 32'h0, rd)
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("status clear", 32'h0, rd)
    bus_wr(wdt_pkg::IEN_ADDR, 32'h00000000);
    bus_rd(wdt_pkg::IEN_ADDR, rd);
    `CHK("ien off", 32'h0, rd)
    $display("test irq regs done");
  endtask : test_irq_regs

  task test_ovf_irq;
    bus_wr(wdt_pkg::IEN_ADDR, 32'h00000001);
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00002020);
    rc_edges(31);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("count max", 15'h000f, rd[30:16])
    `CHK("irq before ovf", 1'b0, irq)
    rc_edges(1);
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("timer ovf status", 32'h00000001, rd)
    `CHK("timer ovf irq", 1'b1, irq)
    `CHK("timer no reset", 0, rst_pulses)
    `CHK("timer no wake", 0, wake_pulses)
    bus_wr(wdt_pkg::CLR_ADDR, 32'h00000001);
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("status cleared", 32'h0, rd)
    `CHK("irq cleared", 1'b0, irq)
    $display("test ovf irq done");
  endtask : test_ovf_irq

  task test_ovf_reset;
    bus_wr(wdt_pkg::CTL_ADDR, 32'h00002020);
    rc_edges(32);
    `CHK("reset pulse", 1, rst_pulses)
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("regs kept", 32'h00000050, rd)
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("reset status", 32'h00000002, rd)
    power_mode <= wdt_pkg::WDT_IDLE;
    rc_edges(32);
    `CHK("idle wake", 1, wake_pulses)
    `CHK("idle no reset", 1, rst_pulses)
    `CHK("idle irq", 1'b1, irq)
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("idle status", 32'h00000003, rd)
    bus_wr(wdt_pkg::CLR_ADDR, 32'h00000003);
    power_mode <= wdt_pkg::WDT_NORMAL;
    bus_rd(wdt_pkg::STAT_ADDR, rd);
    `CHK("all cleared", 32'h0, rd)
    $display("test ovf reset done");
  endtask : test_ovf_reset

  task test_srst;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    bus_rd(wdt_pkg::CTL_ADDR, rd);
    `CHK("unlock by srst", 32'h00000007, rd)
    $display("test srst done");
  endtask : test_srst

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_mask();
    test_enable();
    test_count();
    test_modes();
    test_ovf_irq();
    test_action();
    test_ovf_reset();
    test_irq_regs();
    test_srst();
    conclude();
  end
endmodule : wdt_timer_unit_tb
